//--- include/ext_bus_map.svh
// Purpose: Constants for the external bus pin control block
// Assumes: APB word registers, 250 MHz clock
// Notes: Byte offsets are word aligned
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_BANK_SWITCH_CTRL 12'h000
`define OFF_CORE_REQ 12'h004
`define OFF_WRITE_DATA 12'h008
`define OFF_PIN_STATUS 12'h00C
`define OFF_READ_DATA 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_HOLDER_EN 0
`define BIT_REQ_ADDR_LO 0
`define BIT_REQ_WRITE 8
`define BIT_REQ_INTERRUPT_ACK_OUT 9
`define BIT_REQ_DRIVE 10

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define RST_HOLDER_EN 1'b0
`define ADDR_W 6
`define DATA_W 16

`endif

//--- include/ext_bus_pkg.sv
// Purpose: Types for the external bus pin control block
// Assumes: ext_bus_map.svh included first
// Notes: Pin groups travel as packed structs
`include "ext_bus_map.svh"
package ext_bus_pkg;
  // Core-side bus request
  typedef struct packed {
    logic drive;
    logic interrupt_ack_out;
    logic write;
    logic [`ADDR_W-1:0] addr;
  } core_req_t;
  // Two-signal view of a pin group
  typedef struct packed {
    logic [`DATA_W-1:0] out;
    logic [`DATA_W-1:0] oe;
  } data_pins_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_RELEASED} bus_state_t;
endpackage

//--- logic/pin_sync3.sv
// Purpose: Three-stage synchroniser, change taken when stages two and three agree
// Assumes: One clock, synchronous active-low reset
// Notes: First stage read only by second stage
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Shift chain and agreement filter
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_o <= INIT;
    end
    else if (ce_i)
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++)
        if (s2[i] == s3[i])
          q_o[i] <= s3[i];
    end
  end
endmodule // pin_sync3

//--- logic/data_holder.sv
// Purpose: Per-line keeper for the released data bus
// Assumes: Pad level seen through a synchroniser
// Notes: Weak keeper, drive enable never asserted by it
`timescale 1ns/1ps
module data_holder (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic [15:0] pad_level_i,
  output logic [15:0] keep_level_o,
  output logic keep_active_o
);
  // Track last level carried by each line
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      keep_level_o <= 16'h0000;
      keep_active_o <= 1'b0;
    end
    else if (ce_i)
    begin
      keep_level_o <= pad_level_i; // R07
      keep_active_o <= enable_i; // R07
    end
  end
endmodule // data_holder

//--- logic/ext_bus_pin_control.sv
// Purpose: Pin-level control of the simplified external address and data bus
// Assumes: APB slave, 250 MHz REF_CLK_I, synchronous active-low reset
// Notes: Keeper is weak; outputs are separate level and enable signals
// How it works
// R01: Six-bit address out, bit five most significant, bit zero least.
// R02: Address lines released while bus hold is in effect.
// R03: Address lines released while emulation-off input is low.
// R04: One shared sixteen-bit bidirectional data bus, bit fifteen most significant.
// R05: Data bus released unless outputting, and during reset or hold request.
// R06: Data bus released whenever emulation-off is low, overriding transfers.
// R07: Enabled holders keep each undriven line at its last level.
// R08: Holders come out of reset disabled.
// R09: Software sets or clears holder-enable bit in bank-switch control register.
// R10: Interrupt acknowledge asserted when vector fetch begins.
// R11: Address carries vector during acknowledge; acknowledge released when emulation-off low.
// R12: Holder is weak so any external driver overrides it.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "ext_bus_map.svh"

module ext_bus_pin_control (
  // Clock, reset, enable
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Pin inputs
  input wire logic EMULATION_OFF_N_I,
  input wire logic BUS_HOLD_REQ_I,
  input wire logic [15:0] EXT_DATA_I,
  // Address pins
  output logic [5:0] EXT_ADDR_O,
  output logic EXT_ADDR_OE_O,
  // Data pins
  output logic [15:0] EXT_DATA_O,
  output logic [15:0] EXT_DATA_OE_O,
  output logic [15:0] EXT_DATA_KEEP_O,
  output logic EXT_DATA_KEEP_EN_O,
  // Interrupt acknowledge pin
  output logic INTERRUPT_ACK_OUT_O,
  output logic INTERRUPT_ACK_OE_O
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic bus_holder_enable_bit;
  ext_bus_pkg::core_req_t core_req;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic emulation_off_n;
  logic hold_req;
  logic [15:0] pad_level;
  logic [15:0] keep_level;
  logic keep_active;
  logic addr_float;
  logic data_float;
  logic drive_next;
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  ext_bus_pkg::bus_state_t state;
  ext_bus_pkg::bus_state_t next_state;

  // Offset match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Decode one of the mapped offsets
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `OFF_BANK_SWITCH_CTRL) || hit(a, `OFF_CORE_REQ) || hit(a, `OFF_WRITE_DATA)
      || hit(a, `OFF_PIN_STATUS) || hit(a, `OFF_READ_DATA);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  pin_sync3 #(.W(1), .INIT(1'b1)) u_sync_emu (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .d_i(EMULATION_OFF_N_I),
    .q_o(emulation_off_n)
  );
  pin_sync3 #(.W(1), .INIT(1'b0)) u_sync_hold (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .d_i(BUS_HOLD_REQ_I),
    .q_o(hold_req)
  );
  pin_sync3 #(.W(16), .INIT(16'h0000)) u_sync_data (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .d_i(EXT_DATA_I),
    .q_o(pad_level)
  );

  // ----------------------------------------
  // Bus holder
  // ----------------------------------------
  data_holder u_holder (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .enable_i(bus_holder_enable_bit),
    .pad_level_i(data_float ? pad_level : EXT_DATA_O),
    .keep_level_o(keep_level),
    .keep_active_o(keep_active)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign apb_access = PSEL_I && PENABLE_I && CE_I;
  assign apb_wr = apb_access && PWRITE_I;
  assign apb_rd = apb_access && !PWRITE_I;

  // Ready and error, answered in the first access cycle
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else if (CE_I)
    begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped(PADDR_I);
    end
  end

  // Holder enable bit in the bank-switch control register
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
      bus_holder_enable_bit <= `RST_HOLDER_EN; // R08
    else if (apb_wr && PREADY_O && hit(PADDR_I, `OFF_BANK_SWITCH_CTRL))
      bus_holder_enable_bit <= PWDATA_I[`BIT_HOLDER_EN]; // R09
  end

  // Write data register
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
      wr_data <= 16'h0000;
    else if (apb_wr && PREADY_O && hit(PADDR_I, `OFF_WRITE_DATA))
      wr_data <= PWDATA_I[15:0];
  end

  // Core request: address, direction, acknowledge, drive
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
      core_req <= '0;
    else if (apb_wr && PREADY_O && hit(PADDR_I, `OFF_CORE_REQ))
    begin
      core_req.addr <= PWDATA_I[`BIT_REQ_ADDR_LO +: 6]; // R01
      core_req.write <= PWDATA_I[`BIT_REQ_WRITE];
      core_req.interrupt_ack_out <= PWDATA_I[`BIT_REQ_INTERRUPT_ACK_OUT];
      core_req.drive <= PWDATA_I[`BIT_REQ_DRIVE];
    end
  end

  // Read data captured from the bus in ST_DRIVE while the request is not a write
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
      rd_data <= 16'h0000;
    else if (CE_I && state == ext_bus_pkg::ST_DRIVE && !core_req.write)
      rd_data <= pad_level; // R04
  end

  // Read mux
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
      PRDATA_O <= 32'h00000000;
    else if (CE_I && PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      PRDATA_O <= 32'h00000000;
      if (hit(PADDR_I, `OFF_BANK_SWITCH_CTRL))
        PRDATA_O <= {31'h00000000, bus_holder_enable_bit};
      else if (hit(PADDR_I, `OFF_CORE_REQ))
        PRDATA_O <= {21'h000000, core_req.drive, core_req.interrupt_ack_out, core_req.write, 2'h0, core_req.addr};
      else if (hit(PADDR_I, `OFF_WRITE_DATA))
        PRDATA_O <= {16'h0000, wr_data};
      else if (hit(PADDR_I, `OFF_PIN_STATUS))
        PRDATA_O <= {27'h0000000, keep_active, data_float, addr_float, hold_req, emulation_off_n};
      else if (hit(PADDR_I, `OFF_READ_DATA))
        PRDATA_O <= {16'h0000, rd_data};
    end
  end

  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  assign addr_float = hold_req || !emulation_off_n; // R02 R03
  assign data_float = !(state == ext_bus_pkg::ST_DRIVE && core_req.write) || hold_req
    || !emulation_off_n; // R05 R06
  // Data bus driven in the coming cycle, shared by enable and keeper
  assign drive_next = next_state == ext_bus_pkg::ST_DRIVE && core_req.write && !hold_req
    && emulation_off_n; // R05 R06

  // Next state from request and release conditions
  always_comb
  begin
    next_state = state;
    unique case (state)
      ext_bus_pkg::ST_IDLE:
        if (hold_req || !emulation_off_n)
          next_state = ext_bus_pkg::ST_RELEASED;
        else if (core_req.drive)
          next_state = ext_bus_pkg::ST_DRIVE;
      ext_bus_pkg::ST_DRIVE:
        if (hold_req || !emulation_off_n)
          next_state = ext_bus_pkg::ST_RELEASED; // R06
        else if (!core_req.drive)
          next_state = ext_bus_pkg::ST_IDLE;
      ext_bus_pkg::ST_RELEASED:
        if (!hold_req && emulation_off_n)
          next_state = ext_bus_pkg::ST_IDLE;
      default:
        next_state = ext_bus_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
      state <= ext_bus_pkg::ST_IDLE;
    else if (CE_I)
      state <= next_state;
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Address pins and enable
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      EXT_ADDR_O <= 6'h00;
      EXT_ADDR_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      EXT_ADDR_O <= core_req.addr; // R01 R11
      EXT_ADDR_OE_O <= !(hold_req || !emulation_off_n); // R02 R03
    end
  end

  // Data pins and enables, released during reset
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      EXT_DATA_O <= 16'h0000;
      EXT_DATA_OE_O <= 16'h0000; // R05
    end
    else if (CE_I)
    begin
      EXT_DATA_O <= wr_data; // R04
      EXT_DATA_OE_O <= drive_next ? 16'hFFFF : 16'h0000; // R05 R06
    end
  end

  // Weak keeper outputs, only while the bus is released
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      EXT_DATA_KEEP_O <= 16'h0000;
      EXT_DATA_KEEP_EN_O <= 1'b0; // R08
    end
    else if (CE_I)
    begin
      EXT_DATA_KEEP_O <= keep_level; // R07
      EXT_DATA_KEEP_EN_O <= keep_active && !drive_next; // R07 R12
    end
  end

  // Interrupt acknowledge pin
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      INTERRUPT_ACK_OUT_O <= 1'b1;
      INTERRUPT_ACK_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      INTERRUPT_ACK_OUT_O <= !(core_req.interrupt_ack_out && core_req.drive); // R10
      INTERRUPT_ACK_OE_O <= emulation_off_n; // R11
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_addr_release_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R02
    CE_I && hold_req |=> !EXT_ADDR_OE_O) else $error("address driven during hold");
  a_addr_release_emu: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R03
    CE_I && !emulation_off_n |=> !EXT_ADDR_OE_O) else $error("address driven with emulation off");
  a_data_release: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R05
    CE_I && (hold_req || !core_req.write) |=> EXT_DATA_OE_O == 16'h0000) else $error("data driven wrongly");
  a_data_emu_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R06
    CE_I && !emulation_off_n |=> EXT_DATA_OE_O == 16'h0000) else $error("data driven with emulation off");
  a_keep_no_fight: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R12
    !(EXT_DATA_KEEP_EN_O && EXT_DATA_OE_O != 16'h0000)) else $error("keeper fights driver");
  a_holder_reset: assert property (@(posedge REF_CLK_I) // R08
    $rose(RST_B_I) |-> !bus_holder_enable_bit) else $error("holder enabled after reset");
  a_holder_write: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R09
    apb_wr && PREADY_O && hit(PADDR_I, `OFF_BANK_SWITCH_CTRL) |=> bus_holder_enable_bit == $past(PWDATA_I[0]))
    else $error("holder bit not written");
  a_interrupt_ack_out_vector: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R10
    CE_I && core_req.interrupt_ack_out && core_req.drive |=> !INTERRUPT_ACK_OUT_O && EXT_ADDR_O == $past(core_req.addr))
    else $error("acknowledge or vector wrong");
  a_interrupt_ack_out_emu_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R11
    CE_I && !emulation_off_n |=> !INTERRUPT_ACK_OE_O) else $error("acknowledge driven with emulation off");
  a_keep_gapless: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R07
    CE_I && keep_active && EXT_DATA_OE_O != 16'h0000 && !drive_next |=> EXT_DATA_KEEP_EN_O
    && EXT_DATA_OE_O == 16'h0000) else $error("keeper gap after drive");
  a_data_oe_whole: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R04
    EXT_DATA_OE_O == 16'h0000 || EXT_DATA_OE_O == 16'hFFFF) else $error("data enable split");
  a_addr_follows: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I) // R01
    CE_I |=> EXT_ADDR_O == $past(core_req.addr)) else $error("address not from request");
  c_write_drive: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I) EXT_DATA_OE_O == 16'hFFFF);
  c_keeper_on: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I) EXT_DATA_KEEP_EN_O);
  c_interrupt_ack_out: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I) !INTERRUPT_ACK_OUT_O);
  c_bus_released: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I) $fell(EXT_ADDR_OE_O));
  c_read_capture: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    state == ext_bus_pkg::ST_DRIVE && !core_req.write);
endmodule // ext_bus_pin_control

//--- verif/ext_mem_model.sv
// Purpose: External memory on the far side of the data bus
// Assumes: Design data pins split into level and enable
// Notes: Undriven, unkept lines show the inverse of their last level
`timescale 1ns/1ps
module ext_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Design side pins
  input wire logic addr_oe_i,
  input wire ext_bus_pkg::data_pins_t dev_i,
  input wire logic [15:0] keep_i,
  input wire logic keep_en_i,
  // Bench control
  input wire logic ans_en_i,
  input wire logic [3:0] ans_dly_i,
  input wire logic [15:0] ans_val_i,
  // Resolved wire
  output logic [15:0] wire_o
);
  logic [15:0] last;
  logic [3:0] cnt;
  logic drv;
  // Wait counter while addressed, last wire level
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !(addr_oe_i && ans_en_i)) cnt <= 4'h0;
    else if (cnt != ans_dly_i) cnt <= cnt + 4'h1;
    // Floating lines keep showing the inverse of their last driven level
    if (!rst_b_i) last <= 16'h0000;
    else if (drv || keep_en_i) last <= wire_o;
    else last <= (wire_o & dev_i.oe) | (last & ~dev_i.oe);
  end
  assign drv = addr_oe_i && ans_en_i && (cnt == ans_dly_i);
  // Per line: device, memory, keeper, else float
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (dev_i.oe[i]) wire_o[i] = dev_i.out[i];
      else if (drv) wire_o[i] = ans_val_i[i];
      else if (keep_en_i) wire_o[i] = keep_i[i];
      else wire_o[i] = ~last[i];
    end
  end
endmodule // ext_mem_model

//--- verif/ext_bus_pin_control_bench.sv
// Purpose: Self-checking bench for the external bus pin control
// Assumes: APB master tasks, 250 MHz clock
// Notes: Memory model resolves the data wire
`timescale 1ns/1ps
module ext_bus_pin_control_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic ce = 1'b1;
  logic emu_n = 1'b1;
  logic hold = 1'b0;
  logic ans_en = 1'b0;
  logic [3:0] ans_dly = 4'h0;
  logic [15:0] ans_val = 16'h0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, addr_oe, keep_en, ack, ack_oe;
  logic [5:0] addr;
  logic [15:0] data_o, data_oe, keep, pad;
  int err_total = 0;
  int n_tests = 0;
  // Clock
  always #2 clk = ~clk;
  ext_bus_pin_control i_ext_bus_pin_control (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .EMULATION_OFF_N_I(emu_n), .BUS_HOLD_REQ_I(hold), .EXT_DATA_I(pad),
    .EXT_ADDR_O(addr), .EXT_ADDR_OE_O(addr_oe), .EXT_DATA_O(data_o), .EXT_DATA_OE_O(data_oe),
    .EXT_DATA_KEEP_O(keep), .EXT_DATA_KEEP_EN_O(keep_en),
    .INTERRUPT_ACK_OUT_O(ack), .INTERRUPT_ACK_OE_O(ack_oe));
  ext_mem_model i_ext_mem_model (
    .clk_i(clk), .rst_b_i(rst_b), .addr_oe_i(addr_oe), .dev_i({data_o, data_oe}),
    .keep_i(keep), .keep_en_i(keep_en), .ans_en_i(ans_en), .ans_dly_i(ans_dly),
    .ans_val_i(ans_val), .wire_o(pad));
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      end_of_test();
    end
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    check(data_oe, 16'h0000, "data floats in reset");
    check(keep_en, 1'b0, "keeper off in reset");
    rst_b <= 1'b1;
    tick(2);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0, "holder bit after reset");
  endtask
  task automatic t_write_drive();
    apb(1'b1, 12'h008, 32'h0000A5C3);
    apb(1'b1, 12'h004, 32'h00000521);
    tick(3);
    check(addr, 6'h21, "address bit order");
    check(data_oe, 16'hFFFF, "data driven");
    check(pad, 16'hA5C3, "data on wire");
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h00000521, "request readback");
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0000A5C3, "write data readback");
    apb(1'b1, 12'h004, 32'h00000021);
    tick(3);
    check(data_oe, 16'h0000, "data released when idle");
  endtask
  task automatic t_read_back();
    ans_en <= 1'b1;
    ans_dly <= 4'h3;
    ans_val <= 16'hBEEF;
    apb(1'b1, 12'h004, 32'h0000041E);
    tick(12);
    check(data_oe, 16'h0000, "no drive on read");
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0000BEEF, "read data");
    ans_en <= 1'b0;
    apb(1'b1, 12'h004, 32'h0);
  endtask
  task automatic t_hold();
    apb(1'b1, 12'h004, 32'h00000521);
    tick(3);
    hold <= 1'b1;
    for (int k = 0; k < 12 && addr_oe !== 1'b0; k++) @(posedge clk);
    check(addr_oe, 1'b0, "address floats in hold");
    check(data_oe, 16'h0000, "data floats in hold");
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0000000F, "status in hold");
    hold <= 1'b0;
    apb(1'b1, 12'h004, 32'h0);
    tick(6);
  endtask
  task automatic t_freeze();
    apb(1'b1, 12'h004, 32'h00000521);
    tick(3);
    ce <= 1'b0;
    hold <= 1'b1;
    tick(10);
    check(addr_oe, 1'b1, "address frozen with enable low");
    check(data_oe, 16'hFFFF, "drive frozen with enable low");
    ce <= 1'b1;
    for (int k = 0; k < 12 && addr_oe !== 1'b0; k++) @(posedge clk);
    check(addr_oe, 1'b0, "address floats once enabled");
    check(data_oe, 16'h0000, "data floats once enabled");
    hold <= 1'b0;
    apb(1'b1, 12'h004, 32'h0);
    tick(6);
  endtask
  task automatic t_emu_ack();
    apb(1'b1, 12'h004, 32'h0000073F);
    tick(3);
    check(ack, 1'b0, "acknowledge asserted");
    check(addr, 6'h3F, "vector on address");
    emu_n <= 1'b0;
    for (int k = 0; k < 12 && ack_oe !== 1'b0; k++) @(posedge clk);
    check(ack_oe, 1'b0, "acknowledge floats");
    check(addr_oe, 1'b0, "address floats");
    check(data_oe, 16'h0000, "data floats mid transfer");
    emu_n <= 1'b1;
    apb(1'b1, 12'h004, 32'h0);
    tick(6);
  endtask
  task automatic t_holder();
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h008, 32'h00005A5A);
    apb(1'b1, 12'h004, 32'h00000500);
    tick(3);
    apb(1'b1, 12'h004, 32'h0);
    tick(4);
    check(keep_en, 1'b1, "keeper on");
    check(pad, 16'h5A5A, "last level kept");
    ans_en <= 1'b1;
    ans_dly <= 4'h0;
    ans_val <= 16'h1234;
    apb(1'b1, 12'h004, 32'h00000400);
    tick(8);
    check(pad, 16'h1234, "external driver wins");
    ans_en <= 1'b0;
    tick(4);
    check(pad, 16'h1234, "new level kept");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    tick(3);
    check(keep_en, 1'b0, "keeper off");
  endtask
  task automatic t_unmapped();
    apb(1'b0, 12'hFFC, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped reads zero");
  endtask
  // Main sequence
  initial
  begin
    tick(16);
    t_reset();
    t_write_drive();
    t_read_back();
    t_hold();
    t_freeze();
    t_emu_ack();
    t_holder();
    t_unmapped();
    end_of_test();
  end
  // Watchdog
  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end
endmodule // ext_bus_pin_control_bench
